/* hw/mtd_ctrl.sv */
// Measurement trigger, result and data-log controller behind an AHB-Lite slave.
// Assumes the measurement engine runs on hclk and pulses meas_done with valid data.
`timescale 1ns/1ps
module mtd_ctrl
  import mtd_pkg::*;
#(
  parameter int LOG_DEPTH = 4000,
  parameter int GAP_CYC = FAST_GAP_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic meas_done,
  input wire logic [31:0] meas_value,
  input wire logic [31:0] meas_temp,
  input wire logic [31:0] meas_comp_value,
  input wire logic [2:0] meas_range,
  input wire logic meas_zero,
  output logic meas_start,
  output logic meas_abort,
  output logic io_flush,
  output logic limit_alarm,
  output logic [6:0] src_current_mag,
  output logic [1:0] src_current_pol,
  output logic [1:0] speed_mode,
  output logic comp_on,
  output logic settle_on
);
  localparam int CW = 12;
  localparam int GW = $clog2(GAP_CYC + 1);
  localparam int REC_W = 37;

  typedef struct packed {
    state_type st;
    logic ready;
    logic resp;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] rdata;
    speed_type speed;
    logic cont_en, log_en, lim_en, alarm_en, comp_en, comp_ext, settle_en, serial_mode;
    logic [6:0] cur_mag;
    pol_type cur_pol;
    func_type func;
    logic meas_avail, read_pend, log_run, log_step;
    logic [31:0] last_val, last_temp, last_comp, out_buf, out_info;
    logic esr_exec, esr_cmd, q_low, q_high;
    logic [14:0] lim_lo, lim_hi;
    logic [CW-1:0] log_cap, log_cnt, rd_idx;
    logic rd_all;
    logic [LOG_DEPTH-1:0][REC_W-1:0] log_mem;
    logic [31:0] st_min, st_max;
    logic [2:0] st_rng;
    logic st_mixed;
    logic [GW-1:0] gap;
    logic meas_start, meas_abort, io_flush, alarm;
  } regs_type;

  regs_type s_q, s_d;
  logic go;
  logic busy;
  logic [3:0] wcode;
  func_type fsel;
  logic [32:0] fres;
  logic [REC_W-1:0] rec;
  logic [31:0] lo_mohm, hi_mohm;

  assign lo_mohm = 32'(32'(s_q.lim_lo) * MILLI_PER_OHM);
  assign hi_mohm = 32'(32'(s_q.lim_hi) * MILLI_PER_OHM);
  assign busy = (s_q.st == ST_MEAS) && !s_q.cont_en && !s_q.log_run;

  // Error flag in bit 32, reading below
  function automatic logic [32:0] fetch_of(func_type f, logic ce, logic external_probe_source, logic [31:0] v, logic [31:0] t,
                                           logic [31:0] c);
    if (f == FUNC_TEMP) begin
      return (ce && external_probe_source) ? {1'b0, t} : {1'b1, ERR_VALUE};
    end else if (f == FUNC_COMP) begin
      return ce ? {1'b0, c} : {1'b1, ERR_VALUE};
    end
    return {1'b0, v};
  endfunction : fetch_of

  function automatic logic [31:0] info_of(logic [CW-1:0] idx, logic [REC_W-1:0] r);
    return {4'h0, idx, 11'h000, r[36:32]};
  endfunction : info_of

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    s_d = s_q;
    go = 1'b0;
    wcode = hwdata[3:0];
    fsel = hwdata[6] ? func_type'(hwdata[5:4]) : s_q.func;
    fres = '0;
    rec = '0;
    s_d.meas_start = 1'b0;
    s_d.meas_abort = 1'b0;
    s_d.io_flush = 1'b0;
    s_d.alarm = 1'b0;
    s_d.ready = 1'b1;
    s_d.resp = 1'b0;
    if (s_q.gap != '0) begin
      s_d.gap = s_q.gap - 1'b1;
    end
    // Write data phase
    if (s_q.wr_pend) begin
      if (s_q.wr_addr == ADDR_CFG) begin
        s_d.speed = speed_type'(hwdata[1:0]);
        s_d.cont_en = hwdata[2];
        s_d.log_en = hwdata[3];
        s_d.lim_en = hwdata[4];
        s_d.alarm_en = hwdata[5];
        s_d.comp_ext = hwdata[7];
        s_d.serial_mode = hwdata[9];
        s_d.comp_en = hwdata[6] && (hwdata[1:0] != SPEED_FAST);
        s_d.settle_en = hwdata[8] && (hwdata[1:0] != SPEED_FAST) && (s_q.cur_pol != POL_AVG);
        if ((hwdata[6] || hwdata[8]) && hwdata[1:0] == SPEED_FAST) begin
          s_d.esr_exec = 1'b1;
        end
        if (hwdata[1:0] == SPEED_FAST && s_q.cur_pol == POL_AVG) begin
          s_d.cur_pol = POL_POS;
        end
        if (!hwdata[3]) begin
          s_d.log_run = 1'b0;
        end
      end else if (s_q.wr_addr == ADDR_CUR) begin
        if (hwdata[6:0] < CUR_MAG_MIN || hwdata[6:0] > CUR_MAG_MAX || hwdata[9:8] > POL_AVG) begin
          s_d.esr_exec = 1'b1;
        end else if (hwdata[9:8] == POL_AVG && s_q.speed == SPEED_FAST) begin
          s_d.esr_exec = 1'b1;
        end else begin
          s_d.cur_mag = hwdata[6:0];
          s_d.cur_pol = pol_type'(hwdata[9:8]);
          if (hwdata[9:8] == POL_AVG) begin
            s_d.settle_en = 1'b0;
          end
          s_d.meas_abort = 1'b1;
          s_d.st = ST_IDLE;
          s_d.read_pend = 1'b0;
          s_d.log_step = 1'b0;
        end
      end else if (s_q.wr_addr == ADDR_CMD) begin
        if (busy && wcode != CMD_CANCEL && wcode != CMD_LOG_HALT) begin
          s_d.esr_cmd = 1'b1;
        end else begin
          case (wcode)
            CMD_SINGLE_SHOT, CMD_COMMON_TRIGGER: begin
              if (s_q.cont_en || s_q.log_en) begin
                s_d.esr_exec = 1'b1;
              end else begin
                go = 1'b1;
              end
            end
            CMD_READ: begin
              if (s_q.cont_en || s_q.log_en) begin
                s_d.esr_exec = 1'b1;
                s_d.out_buf = ERR_VALUE;
              end else begin
                go = 1'b1;
                s_d.read_pend = 1'b1;
                s_d.func = fsel;
              end
            end
            CMD_FETCH: begin
              fres = fetch_of(fsel, s_q.comp_en, s_q.comp_ext, s_q.last_val, s_q.last_temp, s_q.last_comp);
              s_d.func = fsel;
              s_d.out_buf = fres[31:0];
              s_d.esr_exec = s_q.esr_exec | fres[32];
              s_d.meas_avail = 1'b0;
            end
            CMD_CANCEL: begin
              if (s_q.serial_mode) begin
                s_d.meas_abort = 1'b1;
                s_d.io_flush = 1'b1;
                s_d.st = ST_IDLE;
                s_d.read_pend = 1'b0;
                s_d.log_step = 1'b0;
                s_d.rd_all = 1'b0;
              end else begin
                s_d.esr_cmd = 1'b1;
              end
            end
            CMD_LOG_RUN: begin
              if (!s_q.log_en || s_q.log_cnt >= s_q.log_cap) begin
                s_d.esr_exec = 1'b1;
              end else begin
                s_d.log_run = 1'b1;
              end
            end
            CMD_LOG_HALT: begin
              s_d.log_run = 1'b0;
              s_d.log_step = 1'b0;
              s_d.meas_abort = 1'b1;
              s_d.st = ST_IDLE;
            end
            CMD_LOG_SINGLE: begin
              if (!s_q.log_en || s_q.log_cnt >= s_q.log_cap) begin
                s_d.esr_exec = 1'b1;
              end else begin
                s_d.log_run = 1'b0;
                s_d.log_step = 1'b1;
                go = (s_q.st == ST_IDLE);
              end
            end
            CMD_LOG_ERASE: begin
              s_d.log_cnt = '0;
              s_d.st_mixed = 1'b0;
            end
            CMD_LOG_READOUT: begin
              if (s_q.log_cnt == '0 || (!hwdata[15] && (hwdata[27:16] == 12'h000 || hwdata[27:16] > s_q.log_cnt)))
              begin
                s_d.esr_exec = 1'b1;
                s_d.out_buf = ERR_VALUE;
              end else begin
                s_d.rd_idx = hwdata[15] ? 12'd1 : hwdata[27:16];
                s_d.rd_all = hwdata[15];
                rec = s_q.log_mem[s_d.rd_idx - 1'b1];
                s_d.out_buf = rec[31:0];
                s_d.out_info = info_of(s_d.rd_idx, rec);
              end
            end
            CMD_STATS: begin
              if (s_q.log_cnt < 12'd2 || s_q.st_mixed) begin
                s_d.esr_exec = 1'b1;
                s_d.out_buf = ERR_VALUE;
              end else if (hwdata[5:4] == STAT_MIN) begin
                s_d.out_buf = s_q.st_min;
              end else if (hwdata[5:4] == STAT_MAX) begin
                s_d.out_buf = s_q.st_max;
              end else begin
                s_d.out_buf = s_q.st_max - s_q.st_min;
              end
            end
            default: begin
              s_d.esr_cmd = 1'b1;
            end
          endcase
        end
      end else if (s_q.wr_addr == ADDR_STATUS) begin
        s_d.esr_exec = s_q.esr_exec & ~hwdata[BIT_ESR_EXEC];
        s_d.esr_cmd = s_q.esr_cmd & ~hwdata[BIT_ESR_CMD];
      end else if (s_q.wr_addr == ADDR_LOG_CAP) begin
        if (hwdata[31:0] == 32'h0 || hwdata[31:0] > 32'(LOG_CAP_MAX)) begin
          s_d.esr_exec = 1'b1;
        end else begin
          s_d.log_cap = hwdata[CW-1:0];
        end
      end else if (s_q.wr_addr == ADDR_LIM_LO || s_q.wr_addr == ADDR_LIM_HI) begin
        if (hwdata[31:0] > 32'(LIM_MAX)) begin
          s_d.esr_exec = 1'b1;
        end else if (s_q.wr_addr == ADDR_LIM_LO) begin
          s_d.lim_lo = hwdata[14:0];
        end else begin
          s_d.lim_hi = hwdata[14:0];
        end
      end
    end
    // Address phase
    s_d.wr_pend = 1'b0;
    if (hsel && hready && htrans[1]) begin
      if (hwrite) begin
        s_d.wr_pend = 1'b1;
        s_d.wr_addr = haddr[7:0];
      end else begin
        if (haddr[7:0] == ADDR_CFG) begin
          s_d.rdata = {22'h0, s_q.serial_mode, s_q.settle_en, s_q.comp_ext, s_q.comp_en, s_q.alarm_en,
                       s_q.lim_en, s_q.log_en, s_q.cont_en, s_q.speed};
        end else if (haddr[7:0] == ADDR_CUR) begin
          s_d.rdata = {22'h0, s_q.cur_pol, 1'b0, s_q.cur_mag};
        end else if (haddr[7:0] == ADDR_STATUS) begin
          s_d.rdata = '0;
          s_d.rdata[BIT_BUSY] = busy;
          s_d.rdata[BIT_LOG_RUN] = s_q.log_run;
          s_d.rdata[BIT_READOUT] = s_q.rd_all;
          s_d.rdata[BIT_ESR_EXEC] = s_q.esr_exec;
          s_d.rdata[BIT_ESR_CMD] = s_q.esr_cmd;
          s_d.rdata[BIT_MEAS_AVAIL] = s_q.meas_avail;
          s_d.rdata[BIT_LIM_LOW] = s_q.q_low;
          s_d.rdata[BIT_LIM_HIGH] = s_q.q_high;
        end else if (haddr[7:0] == ADDR_RESULT) begin
          s_d.rdata = s_q.out_buf;
          if (s_q.rd_all) begin
            if (s_q.rd_idx >= s_q.log_cnt) begin
              s_d.rd_all = 1'b0;
            end else begin
              rec = s_q.log_mem[s_q.rd_idx];
              s_d.rd_idx = s_q.rd_idx + 1'b1;
              s_d.out_buf = rec[31:0];
              s_d.out_info = info_of(s_d.rd_idx, rec);
            end
          end
        end else if (haddr[7:0] == ADDR_LOG_CAP) begin
          s_d.rdata = {20'h0, s_q.log_cap};
        end else if (haddr[7:0] == ADDR_LOG_CNT) begin
          s_d.rdata = {20'h0, s_q.log_cnt};
        end else if (haddr[7:0] == ADDR_LIM_LO) begin
          s_d.rdata = {17'h0, s_q.lim_lo};
        end else if (haddr[7:0] == ADDR_LIM_HI) begin
          s_d.rdata = {17'h0, s_q.lim_hi};
        end else if (haddr[7:0] == ADDR_INFO) begin
          s_d.rdata = s_q.out_info;
        end else begin
          s_d.rdata = '0;
        end
      end
    end
    // Measurement engine
    if (s_q.st == ST_MEAS && s_d.st == ST_MEAS && meas_done) begin
      s_d.st = ST_IDLE;
      s_d.last_val = meas_value;
      s_d.last_temp = meas_temp;
      s_d.last_comp = meas_comp_value;
      s_d.meas_avail = 1'b1;
      if (s_q.lim_en) begin
        s_d.q_low = meas_value < lo_mohm;
        s_d.q_high = meas_value > hi_mohm;
        s_d.alarm = s_q.alarm_en && (meas_value < lo_mohm || meas_value > hi_mohm);
      end
      if ((s_d.log_run || s_d.log_step) && s_q.log_cnt < s_q.log_cap) begin
        s_d.log_mem[s_q.log_cnt] = {s_q.comp_en, meas_zero, meas_range, meas_value};
        s_d.log_cnt = s_q.log_cnt + 1'b1;
        if (s_q.log_cnt == '0) begin
          s_d.st_min = meas_value;
          s_d.st_max = meas_value;
          s_d.st_rng = meas_range;
        end else begin
          s_d.st_min = (meas_value < s_q.st_min) ? meas_value : s_q.st_min;
          s_d.st_max = (meas_value > s_q.st_max) ? meas_value : s_q.st_max;
          s_d.st_mixed = s_q.st_mixed | (meas_range != s_q.st_rng);
        end
        if (s_d.log_cnt >= s_q.log_cap) begin
          s_d.log_run = 1'b0;
        end
      end
      s_d.log_step = 1'b0;
      if (s_q.read_pend) begin
        fres = fetch_of(s_q.func, s_q.comp_en, s_q.comp_ext, meas_value, meas_temp, meas_comp_value);
        s_d.out_buf = fres[31:0];
        s_d.esr_exec = s_d.esr_exec | fres[32];
        s_d.meas_avail = 1'b0;
        s_d.read_pend = 1'b0;
      end
    end
    if (s_d.st == ST_IDLE && s_d.gap == '0 && ((s_d.cont_en && !s_d.log_en) || s_d.log_run)) begin
      go = 1'b1;
    end
    if (go) begin
      s_d.st = ST_MEAS;
      s_d.meas_start = 1'b1;
      s_d.gap = (s_d.speed == SPEED_FAST) ? GW'(GAP_CYC - 1) : '0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '0;
      s_q.ready <= 1'b1;
      s_q.cur_mag <= CUR_MAG_RST;
      s_q.log_cap <= LOG_CAP_RST;
      s_q.lim_hi <= LIM_HI_RST;
      s_q.alarm_en <= 1'b1;
      s_q.serial_mode <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign hrdata = s_q.rdata;
  assign hreadyout = s_q.ready;
  assign hresp = s_q.resp;
  assign meas_start = s_q.meas_start;
  assign meas_abort = s_q.meas_abort;
  assign io_flush = s_q.io_flush;
  assign limit_alarm = s_q.alarm;
  assign src_current_mag = s_q.cur_mag;
  assign src_current_pol = s_q.cur_pol;
  assign speed_mode = s_q.speed;
  assign comp_on = s_q.comp_en;
  assign settle_on = s_q.settle_en;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  logic cmd_wr;
  assign cmd_wr = s_q.wr_pend && s_q.wr_addr == ADDR_CMD && !busy;

  property p_fast_forces;
    @(posedge hclk) disable iff (!hresetn)
      s_q.speed == SPEED_FAST |-> s_q.cur_pol != POL_AVG && !s_q.comp_en && !s_q.settle_en;
  endproperty
  a_fast_forces: assert property (p_fast_forces) else $error("fast mode left a feature on");

  property p_cur_abort;
    @(posedge hclk) disable iff (!hresetn)
      (s_q.wr_pend && s_q.wr_addr == ADDR_CUR && hwdata[6:0] >= CUR_MAG_MIN && hwdata[6:0] <= CUR_MAG_MAX
       && hwdata[9:8] == POL_NEG) |=> meas_abort && src_current_pol == POL_NEG;
  endproperty
  a_cur_abort: assert property (p_cur_abort) else $error("current change did not abort");

  property p_avg_fast_refused;
    @(posedge hclk) disable iff (!hresetn)
      (s_q.wr_pend && s_q.wr_addr == ADDR_CUR && hwdata[9:8] == POL_AVG && s_q.speed == SPEED_FAST)
      |=> s_q.esr_exec && s_q.cur_pol == $past(s_q.cur_pol) && !meas_abort;
  endproperty
  a_avg_fast_refused: assert property (p_avg_fast_refused) else $error("averaged current taken in fast mode");

  property p_avg_settle;
    @(posedge hclk) disable iff (!hresetn) s_q.cur_pol == POL_AVG |-> !s_q.settle_en;
  endproperty
  a_avg_settle: assert property (p_avg_settle) else $error("settling on with averaged current");

  property p_done_avail;
    @(posedge hclk) disable iff (!hresetn)
      (s_q.st == ST_MEAS && meas_done && !s_q.read_pend && !s_q.wr_pend)
      |=> s_q.meas_avail && (s_q.st == ST_IDLE || s_q.meas_start);
  endproperty
  a_done_avail: assert property (p_done_avail) else $error("completion did not set available");

  property p_trig_refused;
    @(posedge hclk) disable iff (!hresetn)
      (cmd_wr && hwdata[3:0] == CMD_SINGLE_SHOT && (s_q.cont_en || s_q.log_en)) |=> s_q.esr_exec;
  endproperty
  a_trig_refused: assert property (p_trig_refused) else $error("trigger accepted while not allowed");

  property p_cancel_parallel;
    @(posedge hclk) disable iff (!hresetn)
      (cmd_wr && hwdata[3:0] == CMD_CANCEL && !s_q.serial_mode) |=> s_q.esr_cmd && !io_flush;
  endproperty
  a_cancel_parallel: assert property (p_cancel_parallel) else $error("cancel on parallel bus not refused");

  property p_cap_range;
    @(posedge hclk) disable iff (!hresetn) s_q.log_cap >= 12'd1 && s_q.log_cap <= LOG_CAP_MAX;
  endproperty
  a_cap_range: assert property (p_cap_range) else $error("log capacity out of range");

  property p_erase;
    @(posedge hclk) disable iff (!hresetn)
      (cmd_wr && hwdata[3:0] == CMD_LOG_ERASE && !meas_done) |=> s_q.log_cnt == '0;
  endproperty
  a_erase: assert property (p_erase) else $error("erase left stored readings");

  property p_high_flag;
    @(posedge hclk) disable iff (!hresetn)
      (s_q.st == ST_MEAS && meas_done && s_q.lim_en && meas_value > hi_mohm && !s_q.wr_pend) |=> s_q.q_high;
  endproperty
  a_high_flag: assert property (p_high_flag) else $error("upper bound violation not flagged");
endmodule : mtd_ctrl

/* hw/mtd_pkg.sv */
// Constants, encodings and register map of the measurement trigger and log controller.
// Assumes a 100 MHz bus clock; all packages import-only, no logic.
package mtd_pkg;
  // ----------------------------------------
  // Register byte addresses
  // ----------------------------------------
  localparam logic [7:0] ADDR_CFG = 8'h00;
  localparam logic [7:0] ADDR_CUR = 8'h04;
  localparam logic [7:0] ADDR_CMD = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_RESULT = 8'h10;
  localparam logic [7:0] ADDR_LOG_CAP = 8'h14;
  localparam logic [7:0] ADDR_LOG_CNT = 8'h18;
  localparam logic [7:0] ADDR_LIM_LO = 8'h1C;
  localparam logic [7:0] ADDR_LIM_HI = 8'h20;
  localparam logic [7:0] ADDR_INFO = 8'h24;
  // ----------------------------------------
  // Command codes (CMD register bits 3:0)
  // ----------------------------------------
  localparam logic [3:0] CMD_SINGLE_SHOT = 4'h1;
  localparam logic [3:0] CMD_FETCH = 4'h2;
  localparam logic [3:0] CMD_READ = 4'h3;
  localparam logic [3:0] CMD_CANCEL = 4'h4;
  localparam logic [3:0] CMD_LOG_RUN = 4'h5;
  localparam logic [3:0] CMD_LOG_HALT = 4'h6;
  localparam logic [3:0] CMD_LOG_SINGLE = 4'h7;
  localparam logic [3:0] CMD_LOG_ERASE = 4'h8;
  localparam logic [3:0] CMD_LOG_READOUT = 4'h9;
  localparam logic [3:0] CMD_STATS = 4'hA;
  localparam logic [3:0] CMD_COMMON_TRIGGER = 4'hB;
  // ----------------------------------------
  // Encodings
  // ----------------------------------------
  typedef enum logic [1:0] {SPEED_SLOW = 2'h0, SPEED_MED = 2'h1, SPEED_FAST = 2'h2} speed_type;
  typedef enum logic [1:0] {POL_POS = 2'h0, POL_NEG = 2'h1, POL_AVG = 2'h2} pol_type;
  typedef enum logic [1:0] {FUNC_RES = 2'h0, FUNC_TEMP = 2'h1, FUNC_COMP = 2'h2} func_type;
  typedef enum logic {ST_IDLE, ST_MEAS} state_type;
  localparam logic [1:0] STAT_MIN = 2'h0;
  localparam logic [1:0] STAT_MAX = 2'h1;
  // ----------------------------------------
  // Status bit positions
  // ----------------------------------------
  localparam int BIT_BUSY = 0;
  localparam int BIT_LOG_RUN = 1;
  localparam int BIT_READOUT = 2;
  localparam int BIT_ESR_EXEC = 4;
  localparam int BIT_ESR_CMD = 5;
  localparam int BIT_MEAS_AVAIL = 8;
  localparam int BIT_LIM_LOW = 11;
  localparam int BIT_LIM_HIGH = 12;
  // ----------------------------------------
  // Reset values and bounds
  // ----------------------------------------
  localparam logic [6:0] CUR_MAG_MIN = 7'd10;
  localparam logic [6:0] CUR_MAG_MAX = 7'd100;
  localparam logic [6:0] CUR_MAG_RST = 7'd100;
  localparam logic [11:0] LOG_CAP_MAX = 12'd4000;
  localparam logic [11:0] LOG_CAP_RST = 12'd10;
  localparam logic [14:0] LIM_MAX = 15'd30000;
  localparam logic [14:0] LIM_HI_RST = 15'd30000;
  localparam logic [31:0] MILLI_PER_OHM = 32'd1000;
  localparam logic [31:0] ERR_VALUE = 32'hFFFFFFFF;
  // ----------------------------------------
  // Timing: fast mode at most 50 readings per second; only continuous and log-run starts wait for the gap, command starts do not
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int FAST_PERIOD_NS = 20000000;
  localparam int FAST_GAP_CYC = (FAST_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage : mtd_pkg

/* bench/meas_engine_model.sv */
// Behavioural measurement engine answering meas_start after dly cycles.
// Assumes hclk domain; values only valid in the meas_done cycle.
`timescale 1ns/1ps
module meas_engine_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic meas_start,
  input wire logic meas_abort,
  input wire logic [31:0] val,
  input wire logic [7:0] dly,
  output logic meas_done,
  output logic [31:0] meas_value,
  output logic [31:0] meas_temp,
  output logic [31:0] meas_comp_value,
  output logic [2:0] meas_range,
  output logic meas_zero
);
  int cnt;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt <= 0;
      meas_done <= 1'b0;
    end else begin
      meas_done <= 1'b0;
      if (meas_start || meas_abort) begin
        cnt <= meas_start ? dly : 0;
      end else if (cnt == 1) begin
        cnt <= 0;
        meas_done <= 1'b1;
      end else if (cnt > 1) begin
        cnt <= cnt - 1;
      end
    end
  end
  // Outside the done cycle values are scrambled
  assign meas_value = meas_done ? val : ~val;
  assign meas_temp = meas_value ^ 32'h5A5A5A5A;
  assign meas_comp_value = ~meas_value;
  assign meas_range = meas_done ? 3'h1 : 3'h6;
  assign meas_zero = ~meas_done;
endmodule : meas_engine_model

/* bench/measure_trigger_datalog_ctrl_test.sv */
// Self-checking bench of the trigger and log controller over AHB-Lite.
// Assumes the zero-wait slave and the engine model beside it.
`timescale 1ns/1ps
module measure_trigger_datalog_ctrl_test;
  import mtd_pkg::*;
  logic hclk, hresetn, hsel, hwrite, md, ms, ma, mz;
  logic [1:0] htrans, pol;
  logic [2:0] mr;
  logic [31:0] haddr, hwdata, hrdata, mv, mt, mc, val, s, exp_v;
  logic hreadyout, hresp;
  logic [7:0] dly;
  int fails, tests_run, cyc, aborts;
  mtd_ctrl #(.GAP_CYC(8)) mtd_ctrl_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .meas_done(md), .meas_value(mv), .meas_temp(mt),
    .meas_comp_value(mc), .meas_range(mr), .meas_zero(mz), .meas_start(ms), .meas_abort(ma),
    .io_flush(), .limit_alarm(), .src_current_mag(), .src_current_pol(pol), .speed_mode(),
    .comp_on(), .settle_on());
  meas_engine_model meas_engine_model_inst (.hclk(hclk), .hresetn(hresetn), .meas_start(ms),
    .meas_abort(ma), .val(val), .dly(dly), .meas_done(md), .meas_value(mv), .meas_temp(mt),
    .meas_comp_value(mc), .meas_range(mr), .meas_zero(mz));
  // ----------------------------------------
  // Bus and check tasks
  // ----------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1; haddr <= {24'h0, a}; htrans <= 2'h2; hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0; hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask : wr
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    xfer(1'b0, a, 32'h0, r);
    chk(r, exp);
  endtask : rchk
  task automatic trig(input logic [3:0] c);
    wr(ADDR_CMD, {28'h0, c});
    s = 32'h0;
    for (int i = 0; i < 40 && s[BIT_MEAS_AVAIL] !== 1'b1; i++) xfer(1'b0, ADDR_STATUS, 32'h0, s);
  endtask : trig
  task automatic end_of_test;
    $display("Comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_of_test
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    if (ma === 1'b1) aborts++;
    cyc++;
    if (cyc > 20000) begin
      fails++;
      end_of_test();
    end
  end
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0; hwdata = 32'h0;
    val = 32'h9; dly = 8'h1; fails = 0; tests_run = 0; cyc = 0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    rchk(ADDR_CUR, 32'h00000064);
    rchk(ADDR_LOG_CAP, 32'h0000000A);
    rchk(8'h80, 32'h0);
    $display("reset values done");
    for (int k = 0; k < 2; k++) begin
      val <= lfsr(val); dly <= k ? 8'd20 : 8'd1;
      @(posedge hclk);
      exp_v = val;
      trig(k ? CMD_COMMON_TRIGGER : CMD_SINGLE_SHOT);
      chk({31'h0, s[BIT_MEAS_AVAIL]}, 32'h1);
      wr(ADDR_CMD, {28'h0, CMD_FETCH});
      rchk(ADDR_RESULT, exp_v);
      xfer(1'b0, ADDR_STATUS, 32'h0, s);
      chk({31'h0, s[BIT_MEAS_AVAIL]}, 32'h0);
    end
    $display("single shot done");
    wr(ADDR_CFG, 32'h00000204);
    wr(ADDR_CMD, {28'h0, CMD_SINGLE_SHOT});
    xfer(1'b0, ADDR_STATUS, 32'h0, s);
    chk({31'h0, s[BIT_ESR_EXEC]}, 32'h1);
    wr(ADDR_CFG, 32'h00000202);
    wr(ADDR_STATUS, 32'h00000010);
    wr(ADDR_CUR, 32'h00000232);
    rchk(ADDR_CUR, 32'h00000064);
    xfer(1'b0, ADDR_STATUS, 32'h0, s);
    chk({31'h0, s[BIT_ESR_EXEC]}, 32'h1);
    chk({30'h0, pol}, 32'h0);
    $display("refusals done");
    wr(ADDR_CFG, 32'h00000300);
    rchk(ADDR_CFG, 32'h00000300);
    wr(ADDR_CUR, 32'h00000150);
    rchk(ADDR_CUR, 32'h00000150);
    chk({30'h0, pol}, 32'h1);
    chk(aborts, 32'h1);
    wr(ADDR_CUR, 32'h00000264);
    rchk(ADDR_CFG, 32'h00000200);
    $display("current and settling done");
    wr(ADDR_LIM_HI, 32'h0);
    wr(ADDR_CFG, 32'h00000210);
    wr(ADDR_CMD, {28'h0, CMD_FETCH});
    trig(CMD_SINGLE_SHOT);
    chk({31'h0, s[BIT_LIM_HIGH]}, 32'h1);
    wr(ADDR_CFG, 32'h0);
    wr(ADDR_CMD, {28'h0, CMD_CANCEL});
    xfer(1'b0, ADDR_STATUS, 32'h0, s);
    chk({31'h0, s[BIT_ESR_CMD]}, 32'h1);
    $display("limits and cancel done");
    wr(ADDR_CMD, {28'h0, CMD_FETCH});
    wr(ADDR_CFG, 32'h00000008);
    exp_v = val;
    trig(CMD_LOG_SINGLE);
    rchk(ADDR_LOG_CNT, 32'h1);
    wr(ADDR_CMD, 32'h00010009);
    rchk(ADDR_RESULT, exp_v);
    wr(ADDR_CMD, {28'h0, CMD_LOG_ERASE});
    rchk(ADDR_LOG_CNT, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    $display("log done");
    wr(ADDR_LOG_CAP, 32'h00000FA0);
    rchk(ADDR_LOG_CAP, 32'h00000FA0);
    $display("log capacity done");
    end_of_test();
  end
endmodule : measure_trigger_datalog_ctrl_test
